// [verilog/tpo_consts.svh]
/*
 Offsets, reset values and field layout of the timer pattern output block.
 Assumes byte addresses on AXI4-Lite, eight address bits decoded.
*/
`ifndef TPO_CONSTS_SVH
`define TPO_CONSTS_SVH
`define TPO_ADDR_W 8
`define TPO_OFF_MODE 8'ha0
`define TPO_OFF_TRIG 8'ha4
`define TPO_OFF_EN_HI 8'ha8
`define TPO_OFF_EN_LO 8'hac
`define TPO_OFF_ND_HI_A 8'hb0
`define TPO_OFF_ND_HI_B 8'hb4
`define TPO_OFF_ND_LO_A 8'hb8
`define TPO_OFF_ND_LO_B 8'hbc
`define TPO_RST_NOV 4'h0
`define TPO_RST_TRIG 8'hff
`define TPO_RST_EN 8'h00
`define TPO_RST_DATA 16'h0000
`define TPO_NIB_ONES 4'hf
`define TPO_BYTE_ONES 8'hff
`define TPO_RESP_OKAY 2'h0
`define TPO_RESP_SLVERR 2'h2
`endif

// [verilog/tpo_pkg.sv]
/*
 Types of the timer pattern output block: bus carriers and state records.
 Assumes tpo_consts.svh is on the include path.
*/
`include "tpo_consts.svh"
package tpo_pkg;
    typedef struct packed {
        logic awvalid;
        logic [`TPO_ADDR_W-1:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [`TPO_ADDR_W-1:0] araddr;
        logic rready;
    } tpo_axi_req_type;
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } tpo_axi_rsp_type;
    typedef struct packed {
        logic wr;
        logic [`TPO_ADDR_W-1:0] waddr;
        logic [7:0] wdata;
        logic wbyte;
        logic rd;
        logic [`TPO_ADDR_W-1:0] raddr;
    } tpo_reg_req_type;
    typedef struct packed {
        logic whit;
        logic rhit;
        logic [7:0] rdata;
    } tpo_reg_rsp_type;
    typedef struct packed {
        logic aw_have;
        logic [`TPO_ADDR_W-1:0] awaddr;
        logic w_have;
        logic [7:0] wdata;
        logic wbyte;
        logic bvalid;
        logic [1:0] bresp;
        logic ar_have;
        logic [`TPO_ADDR_W-1:0] araddr;
        logic rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
    } tpo_slave_state_type;
    typedef struct packed {
        logic [3:0] nonoverlap;
        logic [7:0] trig_sel;
        logic [7:0] en_hi;
        logic [7:0] en_lo;
        logic [15:0] staged;
        logic [15:0] pattern;
    } tpo_core_state_type;
endpackage

// [verilog/tpo_group_xfer.sv]
/*
 Next-value logic of one four-bit pattern output group.
 Assumes the caller has already routed the selected channel's compare matches in.
*/
`timescale 1ns/10ps
module tpo_group_xfer (
    input wire logic nonoverlap_i,
    input wire logic match_a_i,
    input wire logic match_b_i,
    input wire logic [3:0] enable_i,
    input wire logic [3:0] staged_i,
    input wire logic [3:0] current_i,
    output logic [3:0] next_o
);
    always_comb begin
        next_o = current_i;
        if (match_a_i) begin
            next_o = (staged_i & enable_i) | (current_i & ~enable_i);
        end else if (nonoverlap_i && match_b_i) begin
            // Falling bits go first so a rising bit never overlaps a falling one
            next_o = current_i & (staged_i | ~enable_i);
        end
    end
endmodule

// [verilog/tpo_axil_slave.sv]
/*
 AXI4-Lite slave front end: one write and one read in flight, one-cycle answer.
 Assumes the register core answers hits and read data combinationally.
*/
`timescale 1ns/10ps
`include "tpo_consts.svh"
module tpo_axil_slave (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire tpo_pkg::tpo_axi_req_type axi_req_i,
    output tpo_pkg::tpo_axi_rsp_type axi_rsp_o,
    output tpo_pkg::tpo_reg_req_type reg_req_o,
    input wire tpo_pkg::tpo_reg_rsp_type reg_rsp_i
);
    tpo_pkg::tpo_slave_state_type q;
    tpo_pkg::tpo_slave_state_type d;
    logic wr_go;
    logic rd_go;

    always_comb begin
        d = q;
        wr_go = q.aw_have && q.w_have;
        rd_go = q.ar_have;
        if (axi_req_i.awvalid && axi_rsp_o.awready) begin
            d.aw_have = 1'b1;
            d.awaddr = axi_req_i.awaddr;
        end
        if (axi_req_i.wvalid && axi_rsp_o.wready) begin
            d.w_have = 1'b1;
            d.wdata = axi_req_i.wdata[7:0];
            d.wbyte = axi_req_i.wstrb[0];
        end
        if (wr_go) begin
            d.aw_have = 1'b0;
            d.w_have = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = reg_rsp_i.whit ? `TPO_RESP_OKAY : `TPO_RESP_SLVERR;
        end else if (q.bvalid && axi_req_i.bready) begin
            d.bvalid = 1'b0;
        end
        if (axi_req_i.arvalid && axi_rsp_o.arready) begin
            d.ar_have = 1'b1;
            d.araddr = axi_req_i.araddr;
        end
        if (rd_go) begin
            d.ar_have = 1'b0;
            d.rvalid = 1'b1;
            d.rdata = reg_rsp_i.rdata;
            d.rresp = reg_rsp_i.rhit ? `TPO_RESP_OKAY : `TPO_RESP_SLVERR;
        end else if (q.rvalid && axi_req_i.rready) begin
            d.rvalid = 1'b0;
        end
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // Holding off new addresses while a response waits keeps one transfer per direction
    assign axi_rsp_o.awready = !q.aw_have && !q.bvalid;
    assign axi_rsp_o.wready = !q.w_have && !q.bvalid;
    assign axi_rsp_o.bvalid = q.bvalid;
    assign axi_rsp_o.bresp = q.bresp;
    assign axi_rsp_o.arready = !q.ar_have && !q.rvalid;
    assign axi_rsp_o.rvalid = q.rvalid;
    assign axi_rsp_o.rdata = {24'h000000, q.rdata};
    assign axi_rsp_o.rresp = q.rresp;
    assign reg_req_o.wr = wr_go;
    assign reg_req_o.waddr = q.awaddr;
    assign reg_req_o.wdata = q.wdata;
    assign reg_req_o.wbyte = q.wbyte;
    assign reg_req_o.rd = rd_go;
    assign reg_req_o.raddr = q.araddr;
endmodule

// [verilog/tpo_pattern_core.sv]
/*
 Timer-triggered pattern output unit: sixteen outputs in four groups of four,
 registers over AXI4-Lite. Assumes the timer unit's compare-match pulses are
 on this clock, one cycle wide, so they need no synchroniser.
*/
// Design decision made here: the AXI4-Lite interface to the registers.
// Contract
// - A group in normal mode changes its outputs only at compare match A of its channel.
// - A non-overlap group clears falling bits at match B and loads new data at match A.
// - A two-bit select value 0 to 3 picks timer channel 0 to 3 as the group trigger.
// - Group 0 drives outputs 3:0 with select bits 1:0; group 1 outputs 7:4 with bits 3:2.
// - Group 2 drives outputs 11:8 with select bits 5:4; group 3 outputs 15:12 with 7:6.
// - An upper output whose enable bit is 0 never takes staged data onto port B.
// - An upper output whose enable bit is 1 takes staged data onto port B when triggered.
// - The lower enable register gates outputs 7:0 onto port A in the same way.
// - Staged bytes share one address when both groups share a trigger, else split in two.
`timescale 1ns/10ps
`include "tpo_consts.svh"
module tpo_pattern_core (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire tpo_pkg::tpo_axi_req_type axi_req_i,
    output tpo_pkg::tpo_axi_rsp_type axi_rsp_o,
    input wire logic [3:0] cmp_match_a_i,
    input wire logic [3:0] cmp_match_b_i,
    output logic [7:0] port_a_o,
    output logic [7:0] port_a_oe_o,
    output logic [7:0] port_b_o,
    output logic [7:0] port_b_oe_o
);
    tpo_pkg::tpo_core_state_type q;
    tpo_pkg::tpo_core_state_type d;
    tpo_pkg::tpo_reg_req_type reg_req;
    tpo_pkg::tpo_reg_rsp_type reg_rsp;
    logic [15:0] en_all;
    logic [15:0] grp_next;
    logic [8:0] wr_look;
    logic [8:0] rd_look;

    function automatic logic [1:0] chan_of(input logic [7:0] sel, input logic [1:0] grp);
        return sel[{grp, 1'b0} +: 2];
    endfunction

    function automatic logic pair_same(input logic [7:0] sel, input logic [1:0] grp);
        return chan_of(sel, grp) == chan_of(sel, grp + 2'd1);
    endfunction

    // Returns {hit, data}; a miss reads as zero
    function automatic logic [8:0] read_reg(input tpo_pkg::tpo_core_state_type s,
                                            input logic [7:0] a);
        logic hi_same;
        logic lo_same;
        hi_same = pair_same(s.trig_sel, 2'd2);
        lo_same = pair_same(s.trig_sel, 2'd0);
        case (a)
            `TPO_OFF_MODE: return {1'b1, `TPO_NIB_ONES, s.nonoverlap};
            `TPO_OFF_TRIG: return {1'b1, s.trig_sel};
            `TPO_OFF_EN_HI: return {1'b1, s.en_hi};
            `TPO_OFF_EN_LO: return {1'b1, s.en_lo};
            `TPO_OFF_ND_HI_A: return hi_same ? {1'b1, s.staged[15:8]} :
                                              {1'b1, s.staged[15:12], `TPO_NIB_ONES};
            `TPO_OFF_ND_HI_B: return hi_same ? {1'b1, `TPO_BYTE_ONES} :
                                              {1'b1, `TPO_NIB_ONES, s.staged[11:8]};
            `TPO_OFF_ND_LO_A: return lo_same ? {1'b1, s.staged[7:0]} :
                                              {1'b1, s.staged[7:4], `TPO_NIB_ONES};
            `TPO_OFF_ND_LO_B: return lo_same ? {1'b1, `TPO_BYTE_ONES} :
                                              {1'b1, `TPO_NIB_ONES, s.staged[3:0]};
            default: return 9'h000;
        endcase
    endfunction

    tpo_axil_slave u_slave (
        .clock_i(clock_i),
        .reset_i(reset_i),
        .axi_req_i(axi_req_i),
        .axi_rsp_o(axi_rsp_o),
        .reg_req_o(reg_req),
        .reg_rsp_i(reg_rsp)
    );

    assign en_all = {q.en_hi, q.en_lo};

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : gen_grp
            tpo_group_xfer u_grp (
                .nonoverlap_i(q.nonoverlap[g]),
                .match_a_i(cmp_match_a_i[chan_of(q.trig_sel, 2'(g))]),
                .match_b_i(cmp_match_b_i[chan_of(q.trig_sel, 2'(g))]),
                .enable_i(en_all[g*4 +: 4]),
                .staged_i(q.staged[g*4 +: 4]),
                .current_i(q.pattern[g*4 +: 4]),
                .next_o(grp_next[g*4 +: 4])
            );
        end
    endgenerate

    assign wr_look = read_reg(q, reg_req.waddr);
    assign rd_look = read_reg(q, reg_req.raddr);
    assign reg_rsp.whit = wr_look[8];
    assign reg_rsp.rhit = rd_look[8];
    assign reg_rsp.rdata = rd_look[7:0];

    always_comb begin
        d = q;
        // A trigger in the same cycle as a staged-data write copies the old staged value
        d.pattern = grp_next;
        if (reg_req.wr && reg_req.wbyte) begin
            case (reg_req.waddr)
                `TPO_OFF_MODE: d.nonoverlap = reg_req.wdata[3:0];
                `TPO_OFF_TRIG: d.trig_sel = reg_req.wdata;
                `TPO_OFF_EN_HI: d.en_hi = reg_req.wdata;
                `TPO_OFF_EN_LO: d.en_lo = reg_req.wdata;
                `TPO_OFF_ND_HI_A: begin
                    if (pair_same(q.trig_sel, 2'd2)) begin
                        d.staged[15:8] = reg_req.wdata;
                    end else begin
                        d.staged[15:12] = reg_req.wdata[7:4];
                    end
                end
                `TPO_OFF_ND_HI_B: begin
                    if (!pair_same(q.trig_sel, 2'd2)) begin
                        d.staged[11:8] = reg_req.wdata[3:0];
                    end
                end
                `TPO_OFF_ND_LO_A: begin
                    if (pair_same(q.trig_sel, 2'd0)) begin
                        d.staged[7:0] = reg_req.wdata;
                    end else begin
                        d.staged[7:4] = reg_req.wdata[7:4];
                    end
                end
                `TPO_OFF_ND_LO_B: begin
                    if (!pair_same(q.trig_sel, 2'd0)) begin
                        d.staged[3:0] = reg_req.wdata[3:0];
                    end
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            q.nonoverlap <= `TPO_RST_NOV;
            q.trig_sel <= `TPO_RST_TRIG;
            q.en_hi <= `TPO_RST_EN;
            q.en_lo <= `TPO_RST_EN;
            q.staged <= `TPO_RST_DATA;
            q.pattern <= `TPO_RST_DATA;
        end else begin
            q <= d;
        end
    end

    assign port_a_o = q.pattern[7:0];
    assign port_b_o = q.pattern[15:8];
    assign port_a_oe_o = q.en_lo;
    assign port_b_oe_o = q.en_hi;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);

    sequence s_g0_match_a;
        !q.nonoverlap[0] && cmp_match_a_i[q.trig_sel[1:0]];
    endsequence

    sequence s_g3_b_only;
        q.nonoverlap[3] && cmp_match_b_i[q.trig_sel[7:6]] && !cmp_match_a_i[q.trig_sel[7:6]];
    endsequence

    a_normal_copy: assert property (s_g0_match_a |=>
        port_a_o[3:0] == (($past(q.staged[3:0]) & $past(q.en_lo[3:0]))
                        | ($past(q.pattern[3:0]) & ~$past(q.en_lo[3:0]))))
        else $error("group 0 normal copy wrong");
    a_normal_no_a: assert property ((!q.nonoverlap[0] && !cmp_match_a_i[q.trig_sel[1:0]])
        |=> port_a_o[3:0] == $past(q.pattern[3:0]))
        else $error("group 0 changed without match A");
    a_nonoverlap_fall: assert property (s_g3_b_only |=>
        port_b_o[7:4] == ($past(q.pattern[15:12])
                        & ($past(q.staged[15:12]) | ~$past(q.en_hi[7:4]))))
        else $error("group 3 match B step wrong");
    a_mode_high_ones: assert property ((reg_req.rd && reg_req.raddr == `TPO_OFF_MODE)
        |=> axi_rsp_o.rvalid && axi_rsp_o.rdata[7:4] == `TPO_NIB_ONES)
        else $error("mode upper bits not one");
    a_group1_select: assert property ((!q.nonoverlap[1] && q.en_lo[7:4] == `TPO_NIB_ONES
        && cmp_match_a_i[q.trig_sel[3:2]]) |=> port_a_o[7:4] == $past(q.staged[7:4]))
        else $error("group 1 trigger select wrong");
    a_group3_select: assert property (cmp_match_a_i[q.trig_sel[7:6]]
        |=> port_b_o[7:4] == (($past(q.staged[15:12]) & $past(q.en_hi[7:4]))
                            | ($past(q.pattern[15:12]) & ~$past(q.en_hi[7:4]))))
        else $error("group 3 trigger select wrong");
    a_upper_disabled: assert property ((q.en_hi == `TPO_RST_EN)
        |=> port_b_o == $past(q.pattern[15:8]))
        else $error("disabled upper output changed");
    a_upper_enabled: assert property ((q.en_hi[3:0] == `TPO_NIB_ONES
        && cmp_match_a_i[q.trig_sel[5:4]]) |=> port_b_o[3:0] == $past(q.staged[11:8]))
        else $error("enabled upper output not copied");
    a_lower_disabled: assert property ((q.en_lo == `TPO_RST_EN)
        |=> port_a_o == $past(q.pattern[7:0]))
        else $error("disabled lower output changed");
    a_split_read: assert property ((reg_req.rd && reg_req.raddr == `TPO_OFF_ND_HI_B
        && !pair_same(q.trig_sel, 2'd2)) |=> axi_rsp_o.rdata[7:4] == `TPO_NIB_ONES)
        else $error("split staged byte upper half not one");
    a_idle_holds: assert property ((cmp_match_a_i == 4'h0 && cmp_match_b_i == 4'h0)
        |=> q.pattern == $past(q.pattern))
        else $error("pattern changed without trigger");
endmodule

// [sim/tpo_timer_model.sv]
/*
 Behavioural timer unit: turns fire requests into one-cycle compare-match pulses.
 Assumes the bench raises a fire request for one cycle per wanted match.
*/
`timescale 1ns/10ps
module tpo_timer_model (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic [3:0] fire_a_i,
    input wire logic [3:0] fire_b_i,
    output logic [3:0] match_a_o,
    output logic [3:0] match_b_o
);
    // A held request gives a one-cycle pulse every other cycle, never a match held high
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            match_a_o <= 4'h0;
            match_b_o <= 4'h0;
        end else begin
            match_a_o <= fire_a_i & ~match_a_o;
            match_b_o <= fire_b_i & ~match_b_o;
        end
    end
endmodule

// [sim/tb_timer_pattern_output_ctrl.sv]
/*
 Self-checking bench of the pattern output unit: AXI4-Lite master tasks,
 timer model on the match inputs. Assumes byte offsets of tpo_consts.svh.
*/
`timescale 1ns/10ps
`include "tpo_consts.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fail_count++; \
    $display("FAIL t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_timer_pattern_output_ctrl;
    typedef struct packed {
        logic [1:0] ch;
        logic a;
        logic b;
        logic [3:0] st3;
        logic [7:0] ea;
        logic [7:0] eb;
    } tpo_row_type;
    logic clock_i;
    logic reset_i;
    tpo_pkg::tpo_axi_req_type req;
    tpo_pkg::tpo_axi_rsp_type rsp;
    logic [3:0] fa, fb, ma, mb;
    logic [7:0] pa, pao, pb, pbo, d, e;
    logic [1:0] r;
    int fail_count = 0;
    int compares = 0;
    // Groups 0..3 on channels 0..3, group 3 non-overlap, output 15 disabled
    tpo_row_type rows [8] = '{
        '{2'd0, 1'b1, 1'b0, 4'ha, 8'h0c, 8'h00}, '{2'd1, 1'b1, 1'b0, 4'ha, 8'h3c, 8'h00},
        '{2'd2, 1'b0, 1'b1, 4'ha, 8'h3c, 8'h00}, '{2'd2, 1'b1, 1'b0, 4'ha, 8'h3c, 8'h05},
        '{2'd3, 1'b1, 1'b0, 4'ha, 8'h3c, 8'h25}, '{2'd3, 1'b0, 1'b1, 4'h5, 8'h3c, 8'h05},
        '{2'd3, 1'b1, 1'b0, 4'h5, 8'h3c, 8'h55}, '{2'd3, 1'b1, 1'b1, 4'h2, 8'h3c, 8'h25}};
    tpo_timer_model timer (.clock_i(clock_i), .reset_i(reset_i), .fire_a_i(fa),
        .fire_b_i(fb), .match_a_o(ma), .match_b_o(mb));
    tpo_pattern_core uut (.clock_i(clock_i), .reset_i(reset_i), .axi_req_i(req),
        .axi_rsp_o(rsp), .cmp_match_a_i(ma), .cmp_match_b_i(mb), .port_a_o(pa),
        .port_a_oe_o(pao), .port_b_o(pb), .port_b_oe_o(pbo));
    initial begin
        clock_i = 1'b0;
        forever #12.5 clock_i = ~clock_i;
    end
    task finish_test;
        $display("mismatches %0d of %0d compares", fail_count, compares);
        if (fail_count == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Address and data offered together; each released once taken
    task automatic axw(input logic [7:0] a, input logic [7:0] dd, input logic [3:0] s,
            output logic [1:0] rr);
        int n;
        n = 0;
        @(posedge clock_i);
        req.awvalid <= 1'b1;
        req.awaddr <= a;
        req.wvalid <= 1'b1;
        req.wdata <= {24'h0, dd};
        req.wstrb <= s;
        req.bready <= 1'b1;
        do begin
            @(posedge clock_i);
            n++;
            if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
        end while (!rsp.bvalid && n < 40);
        rr = rsp.bresp;
        req.bready <= 1'b0;
        if (!rsp.bvalid) begin
            fail_count++;
            finish_test();
        end
    endtask
    task automatic axr(input logic [7:0] a, output logic [7:0] dd, output logic [1:0] rr);
        int n;
        n = 0;
        @(posedge clock_i);
        req.arvalid <= 1'b1;
        req.araddr <= a;
        req.rready <= 1'b1;
        do begin
            @(posedge clock_i);
            n++;
            if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
        end while (!rsp.rvalid && n < 40);
        dd = rsp.rdata[7:0];
        rr = rsp.rresp;
        req.rready <= 1'b0;
        if (!rsp.rvalid) begin
            fail_count++;
            finish_test();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] dd);
        logic [1:0] rr;
        axw(a, dd, 4'h1, rr);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] ex);
        axr(a, d, r);
        `CHK(d, ex)
        `CHK(r, `TPO_RESP_OKAY)
    endtask
    // One match request; outputs are settled two edges after the pulse
    task automatic pulse(input logic [1:0] ch, input logic a, input logic b);
        @(posedge clock_i);
        fa <= {3'h0, a} << ch;
        fb <= {3'h0, b} << ch;
        @(posedge clock_i);
        fa <= 4'h0;
        fb <= 4'h0;
        repeat (2) @(posedge clock_i);
        #1;
    endtask
    initial begin
        reset_i = 1'b1;
        req = '0;
        fa = 4'h0;
        fb = 4'h0;
        repeat (5) @(posedge clock_i);
        reset_i <= 1'b0;
        @(posedge clock_i);
        #1;
        `CHK({pa, pb, pao, pbo}, 32'h0)
        rd(8'ha0, 8'hf0);
        rd(8'ha4, 8'hff);
        rd(8'ha8, 8'h00);
        rd(8'hac, 8'h00);
        rd(8'hb0, 8'h00);
        rd(8'hb4, 8'hff);
        axr(8'h40, d, r);
        `CHK({r, d}, {`TPO_RESP_SLVERR, 8'h00})
        axw(8'h44, 8'h12, 4'h1, r);
        `CHK(r, `TPO_RESP_SLVERR)
        wr(8'ha0, 8'hff);
        rd(8'ha0, 8'hff);
        wr(8'ha0, 8'h08);
        rd(8'ha0, 8'hf8);
        wr(8'ha4, 8'he4);
        wr(8'ha8, 8'h7f);
        wr(8'hac, 8'hff);
        wr(8'hb4, 8'h05);
        wr(8'hb8, 8'h30);
        wr(8'hbc, 8'h0c);
        rd(8'hb4, 8'hf5);
        rd(8'hb8, 8'h3f);
        `CHK({pao, pbo}, 16'hff7f)
        foreach (rows[i]) begin
            wr(8'hb0, {rows[i].st3, 4'h0});
            pulse(rows[i].ch, rows[i].a, rows[i].b);
            `CHK({pa, pb}, {rows[i].ea, rows[i].eb})
        end
        e = 8'h3c;
        for (int k = 0; k < 4; k++) begin
            wr(8'ha4, {4'he, k[1:0], k[1:0]});
            wr(8'hb8, 8'h11 << k);
            pulse(k[1:0] + 2'd1, 1'b1, 1'b0);
            `CHK(pa, e)
            e = 8'h11 << k;
            pulse(k[1:0], 1'b1, 1'b0);
            `CHK(pa, e)
        end
        rd(8'hbc, 8'hff);
        axw(8'hac, 8'h00, 4'h0, r);
        `CHK(r, `TPO_RESP_OKAY)
        rd(8'hac, 8'hff);
        wr(8'hac, 8'hf0);
        wr(8'hb8, 8'h00);
        pulse(2'd3, 1'b1, 1'b0);
        `CHK({pa, pao}, 16'h08f0)
        // Reset in mid-run must restore registers and pins
        @(posedge clock_i);
        reset_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        reset_i <= 1'b0;
        @(posedge clock_i);
        #1;
        `CHK({pa, pb, pao, pbo}, 32'h0)
        rd(8'ha0, 8'hf0);
        rd(8'ha4, 8'hff);
        wr(8'hb0, 8'ha5);
        wr(8'hb4, 8'h12);
        rd(8'hb0, 8'ha5);
        rd(8'hb4, 8'hff);
        finish_test();
    end
endmodule
